//--- inc/fbcc_pkg.sv
// Package of constants and types for the fast block channel controller.
package fbcc_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD  = 8'h00;
  localparam logic [7:0] ADDR_SEL  = 8'h04;
  localparam logic [7:0] ADDR_CONF = 8'h08;
  localparam logic [7:0] ADDR_BUF  = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;

  // ------------------------------------------------------------------
  // Command codes and direction codes
  // ------------------------------------------------------------------
  localparam logic [1:0] OP_OPEN   = 2'h0;
  localparam logic [1:0] OP_CLOSE  = 2'h1;
  localparam logic [1:0] OP_BUFFER = 2'h2;
  localparam logic [1:0] OP_SELECT = 2'h3;
  localparam logic [1:0] MODE_IN   = 2'h0; // inbound_only_mode.
  localparam logic [1:0] MODE_OUT  = 2'h1; // outbound_only_mode.
  localparam logic [1:0] MODE_BI   = 2'h2; // Bidirectional mode.

  // ------------------------------------------------------------------
  // Limits, reset values and frame shape
  // ------------------------------------------------------------------
  localparam logic [10:0] LEN_MIN      = 11'h001;
  localparam logic [10:0] LEN_MAX      = 11'h400;
  localparam logic [10:0] LEN_RST      = 11'h000;
  localparam logic [3:0]  SEL_RST      = 4'h1;
  localparam logic [2:0]  LANE_LAST    = 3'h7;  // Eight output channels per frame.
  localparam int          FRAME_SHIFT  = 4;     // Sixteen bytes per frame.
  localparam logic [3:0]  STAT_REM_LSB = 4'h5;  // Busy at bit 0, bits 4 to 1 read zero.

  // ------------------------------------------------------------------
  // Configuration report codes
  // ------------------------------------------------------------------
  localparam logic [2:0] CONF_CLOSED = 3'h0;
  localparam logic [2:0] CONF_OPEN   = 3'h1;
  localparam logic [2:0] CONF_INIT   = 3'h2;
  localparam logic [2:0] CONF_IN     = 3'h3;
  localparam logic [2:0] CONF_OUT    = 3'h4;
  localparam logic [2:0] CONF_BIDIR  = 3'h5;

  // Per logical channel state.
  typedef enum logic [3:0] {
    CH_CLOSED = 4'h1,
    CH_IN     = 4'h2,
    CH_OUT    = 4'h4,
    CH_BIDIR  = 4'h8
  } fbcc_chan_e;

  // Command word as written to the command register.
  typedef struct packed {
    logic [4:0]  rsvd_hi;
    logic [10:0] len;
    logic [6:0]  rsvd_lo;
    logic        has_chan;
    logic [3:0]  chan;
    logic [1:0]  mode;
    logic [1:0]  op;
  } fbcc_cmd_s;

  // Outcome of the last command, bit set means refused for that cause.
  typedef struct packed {
    logic not_open;
    logic bad_len;
    logic bad_mode;
    logic bad_chan;
  } fbcc_result_s;

  // One outbound word with its position in the frame.
  typedef struct packed {
    logic [3:0]  chan;
    logic [2:0]  lane;
    logic        last;
    logic [15:0] data;
  } fbcc_word_s;

  // True when the state lets data flow into the device.
  function automatic logic may_in(input fbcc_chan_e s);
    may_in = (s == CH_IN) || (s == CH_BIDIR);
  endfunction : may_in

  // True when the state lets data flow out of the device.
  function automatic logic may_out(input fbcc_chan_e s);
    may_out = (s == CH_OUT) || (s == CH_BIDIR);
  endfunction : may_out

endpackage : fbcc_pkg

//--- src/fbcc_frame_streamer.sv
// Outbound frame streamer that presents a counted number of sample frames.
`timescale 1ns/100ps
module fbcc_frame_streamer
  import fbcc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic        abort_i,
  input  wire logic [10:0] len_i,
  input  wire logic [3:0]  chan_i,
  output logic      [12:0] samp_addr_o,
  input  wire logic [15:0] samp_data_i,
  output fbcc_word_s       out_o,
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output logic             busy_o,
  output logic      [10:0] remain_o
);

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_ADDR = 4'h2,
    S_DATA = 4'h4,
    S_SHOW = 4'h8
  } fbcc_strm_e;

  fbcc_strm_e  state;
  logic [9:0]  frame;
  logic [2:0]  lane;
  logic        take;
  logic        frame_end;

  assign take      = out_valid_o && out_ready_i;
  assign frame_end = (lane == LANE_LAST);

  // Sequencer: fetch one sample, present it, advance until the count is spent.
  always_ff @(posedge clk_i) begin
    if (rst_i || (abort_i && !start_i)) begin
      state       <= S_IDLE;
      frame       <= '0;
      lane        <= '0;
      remain_o    <= LEN_RST;
      out_valid_o <= 1'b0;
      out_o       <= '0;
      samp_addr_o <= '0;
    end else if (start_i) begin
      frame       <= '0; // A start that meets an abort restarts the count instead of being lost.
      lane        <= '0;
      remain_o    <= len_i;
      out_valid_o <= 1'b0;
      out_o.chan  <= chan_i;
      samp_addr_o <= '0;
      state       <= S_ADDR;
    end else begin
      unique case (state)
        S_IDLE: begin
          state <= S_IDLE;
        end
        S_ADDR: begin
          state <= S_DATA;
        end
        S_DATA: begin
          out_o.data  <= samp_data_i;
          out_o.lane  <= lane;
          out_o.last  <= frame_end && (remain_o == LEN_MIN);
          out_valid_o <= 1'b1;
          state       <= S_SHOW;
        end
        S_SHOW: begin
          if (take) begin
            out_valid_o <= 1'b0;
            if (frame_end) begin
              remain_o <= remain_o - LEN_MIN;
            end
            if (out_o.last) begin
              state <= S_IDLE;
            end else begin
              lane        <= lane + 3'h1;
              frame       <= frame_end ? frame + 10'h001 : frame;
              samp_addr_o <= {frame_end ? frame + 10'h001 : frame, lane + 3'h1};
              state       <= S_ADDR;
            end
          end
        end
      endcase
    end
  end

  assign busy_o = (state != S_IDLE);

endmodule : fbcc_frame_streamer

//--- src/fbcc_top.sv
// Fast block channel controller: command registers, channel states and data paths.
//
// Operation
// - A closed logical channel carries no data until an open command is accepted for it.
// - Open takes inbound-only, outbound-only or bidirectional; inbound words and new buffers are then allowed only that way.
// - Inbound means backplane into the device, outbound means device onto the backplane.
// - Open, close or buffer without a channel number act on the selected channel.
// - The selected channel is held for later commands and is channel one after reset.
// - All eight outputs share one logical channel, unrelated to any output or physical number.
// - Buffer length is 1 to 1024 frames, others are refused, and it resets to zero.
// - Every frame carries eight outputs of two bytes each, so one frame is sixteen bytes.
// - An accepted buffer command sets the amount and readies exactly that many frames.
// - Close returns the channel to closed, frees it and stops its transfers.
// - The configuration query reports closed or one of the three direction states.
`timescale 1ns/100ps
module fbcc_top
  import fbcc_pkg::*;
#(
  parameter int NUM_CH  = 4,
  parameter int LOAD_AW = 13
)(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  input  wire logic               in_valid_i,
  input  wire logic [3:0]         in_chan_i,
  input  wire logic [15:0]        in_data_i,
  output logic                    in_ready_o,
  output logic                    in_refused_o,
  output logic                    load_we_o,
  output logic      [LOAD_AW-1:0] load_addr_o,
  output logic      [15:0]        load_data_o,
  output logic      [12:0]        samp_addr_o,
  input  wire logic [15:0]        samp_data_i,
  output fbcc_word_s              out_o,
  output logic                    out_valid_o,
  input  wire logic               out_ready_i
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  fbcc_chan_e   chan_state [1:NUM_CH];
  logic [3:0]   sel_chan;
  logic [10:0]  buf_len;
  logic [3:0]   conf_idx;
  fbcc_result_s result;
  logic         strm_start;
  logic         strm_abort;
  logic [3:0]   strm_chan;
  logic         strm_busy;
  logic [10:0]  strm_remain;
  logic         wb_go;
  logic         wr_full;
  logic         cmd_go;
  fbcc_cmd_s    cmd;
  logic [3:0]   eff_ch;
  logic         ch_ok;
  fbcc_chan_e   eff_state;
  fbcc_result_s next_result;
  logic         in_ch_ok;
  logic         in_allowed;
  logic [31:0]  rd_data;
  logic [2:0]   conf_code;

  // ------------------------------------------------------------------
  // Wishbone slave handshake
  // ------------------------------------------------------------------

  // A request is served once; ack drops in the cycle after it was given.
  assign wb_go   = cyc_i && stb_i && !ack_o;
  assign wr_full = (sel_i == 4'hF);
  assign cmd_go  = wb_go && we_i && wr_full && (adr_i == ADDR_CMD);

  // Ack follows every request one cycle later, mapped or not.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= wb_go;
    end
  end

  // ------------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------------

  // Resolve the addressed channel and check the command's arguments.
  always_comb begin
    cmd         = fbcc_cmd_s'(dat_i);
    eff_ch      = cmd.has_chan ? cmd.chan : sel_chan;
    if (cmd.op == OP_SELECT) begin
      eff_ch = cmd.chan;
    end
    ch_ok       = (eff_ch != 4'h0) && (int'(eff_ch) <= NUM_CH);
    eff_state   = ch_ok ? chan_state[eff_ch] : CH_CLOSED;
    next_result = '0;
    next_result.bad_chan = !ch_ok;
    unique case (cmd.op)
      OP_OPEN: begin
        next_result.bad_mode = (cmd.mode != MODE_IN) && (cmd.mode != MODE_OUT)
                               && (cmd.mode != MODE_BI);
      end
      OP_BUFFER: begin
        next_result.bad_len  = (cmd.len < LEN_MIN) || (cmd.len > LEN_MAX);
        next_result.not_open = ch_ok && !may_out(eff_state);
      end
      default: begin
        next_result.bad_mode = 1'b0;
      end
    endcase
  end

  // Keep the outcome of the last command for software to read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result <= '0;
    end else if (cmd_go) begin
      result <= next_result;
    end
  end

  // ------------------------------------------------------------------
  // Logical channel states
  // ------------------------------------------------------------------

  // Each channel changes only on an accepted open or close aimed at it.
  for (genvar g = 1; g <= NUM_CH; g++) begin : g_chan
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        chan_state[g] <= CH_CLOSED;
      end else if (cmd_go && (next_result == '0) && (int'(eff_ch) == g)) begin
        if (cmd.op == OP_OPEN) begin
          unique case (cmd.mode)
            MODE_IN:  chan_state[g] <= CH_IN;
            MODE_OUT: chan_state[g] <= CH_OUT;
            default:  chan_state[g] <= CH_BIDIR;
          endcase
        end else if (cmd.op == OP_CLOSE) begin
          chan_state[g] <= CH_CLOSED;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Selection and buffer length
  // ------------------------------------------------------------------

  // The selected channel starts at one and moves only to a valid channel.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_chan <= SEL_RST;
    end else if (cmd_go && (cmd.op == OP_SELECT) && ch_ok) begin
      sel_chan <= cmd.chan;
    end
  end

  // An accepted buffer command stores its length and arms the streamer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_len    <= LEN_RST;
      strm_start <= 1'b0;
      strm_chan  <= SEL_RST;
    end else begin
      strm_start <= 1'b0;
      if (cmd_go && (cmd.op == OP_BUFFER) && (next_result == '0)) begin
        buf_len    <= cmd.len;
        strm_start <= 1'b1;
        strm_chan  <= eff_ch;
      end
    end
  end

  // A new buffer command restarts the count; closing the channel stops it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strm_abort <= 1'b0;
    end else begin
      strm_abort <= cmd_go && (next_result == '0) && (eff_ch == strm_chan)
                    && ((cmd.op == OP_CLOSE) || (cmd.op == OP_BUFFER));
    end
  end

  // ------------------------------------------------------------------
  // Outbound frames
  // ------------------------------------------------------------------

  // Outbound data starts only on a channel that allows it and runs until the count is spent, a close or a new buffer.
  fbcc_frame_streamer u_streamer (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .start_i     (strm_start),
    .abort_i     (strm_abort),
    .len_i       (buf_len),
    .chan_i      (strm_chan),
    .samp_addr_o (samp_addr_o),
    .samp_data_i (samp_data_i),
    .out_o       (out_o),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .busy_o      (strm_busy),
    .remain_o    (strm_remain)
  );

  // ------------------------------------------------------------------
  // Inbound words
  // ------------------------------------------------------------------

  // Inbound words are taken only on a channel open for inbound flow.
  assign in_ch_ok   = (in_chan_i != 4'h0) && (int'(in_chan_i) <= NUM_CH);
  assign in_allowed = in_ch_ok && may_in(chan_state[in_ch_ok ? in_chan_i : SEL_RST]);

  // One-cycle ready per word; a word on a disallowed channel is refused.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_ready_o   <= 1'b0;
      in_refused_o <= 1'b0;
    end else begin
      in_ready_o   <= in_valid_i && !in_ready_o && !in_refused_o && in_allowed;
      in_refused_o <= in_valid_i && !in_ready_o && !in_refused_o && !in_allowed;
    end
  end

  // Accepted words load waveform memory at consecutive addresses.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_we_o   <= 1'b0;
      load_addr_o <= '0;
      load_data_o <= '0;
    end else begin
      load_we_o <= in_ready_o;
      if (in_ready_o) begin
        load_data_o <= in_data_i;
      end
      if (cmd_go && (cmd.op == OP_OPEN)) begin
        load_addr_o <= '0;
      end else if (in_ready_o) begin
        load_addr_o <= load_addr_o + LOAD_AW'(1);
      end
    end
  end

  // ------------------------------------------------------------------
  // Configuration query and register reads
  // ------------------------------------------------------------------

  // Software picks which channel the configuration register reports.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conf_idx <= SEL_RST;
    end else if (wb_go && we_i && wr_full && (adr_i == ADDR_CONF)) begin
      conf_idx <= dat_i[3:0];
    end
  end

  // Report the state of the queried channel.
  always_comb begin
    conf_code = CONF_CLOSED;
    if ((conf_idx != 4'h0) && (int'(conf_idx) <= NUM_CH)) begin
      unique case (chan_state[conf_idx])
        CH_IN:    conf_code = CONF_IN;
        CH_OUT:   conf_code = CONF_OUT;
        CH_BIDIR: conf_code = CONF_BIDIR;
        default:  conf_code = CONF_CLOSED;
      endcase
    end
  end

  // Read multiplexer; unmapped offsets read zero.
  always_comb begin
    rd_data = '0;
    unique case (adr_i)
      ADDR_CMD:  rd_data = {28'h0000000, result};
      ADDR_SEL:  rd_data = {28'h0000000, sel_chan};
      ADDR_CONF: rd_data = {21'h000000, conf_code, 4'h0, conf_idx};
      ADDR_BUF:  rd_data = {6'h00, 15'(buf_len) << FRAME_SHIFT, buf_len};
      ADDR_STAT: rd_data = (32'(strm_remain) << STAT_REM_LSB) | 32'(strm_busy);
      default:   rd_data = '0;
    endcase
  end

  // Read data is registered together with ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (wb_go) begin
      dat_o <= we_i ? '0 : rd_data;
    end
  end

endmodule : fbcc_top

//--- test/fbcc_host_model.sv
// Far-side model: waveform sample memory and a host sink that stalls.
`timescale 1ns/100ps
module fbcc_host_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [12:0] samp_addr_i,
  output logic      [15:0] samp_data_o,
  output logic             out_ready_o
);
  logic [1:0] pace;

  // Synchronous sample memory, two bytes per output channel word.
  always_ff @(posedge clk_i) begin
    samp_data_o <= {3'h5, samp_addr_i};
  end

  // Host takes words only half of the time.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pace <= 2'h0;
    end else begin
      pace <= pace + 2'h1;
    end
  end
  assign out_ready_o = pace[1];
endmodule : fbcc_host_model

//--- test/fbcc_top_properties.sv
// Port-level checker for the fast block channel controller.
`timescale 1ns/100ps
module fbcc_top_checker
  import fbcc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic        in_valid_i,
  input wire logic [15:0] in_data_i,
  input wire logic        in_ready_o,
  input wire logic        in_refused_o,
  input wire logic        load_we_o,
  input wire logic [15:0] load_data_o,
  input wire fbcc_word_s  out_o,
  input wire logic        out_valid_o,
  input wire logic        out_ready_i
);
  logic [2:0] exp_lane;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Lane expected on the next outbound word, advanced at each handshake.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exp_lane <= 3'h0;
    end else if (out_valid_o && out_ready_i) begin
      exp_lane <= out_o.lane + 3'h1;
    end
  end

  a_refused_no_load: assert property (in_refused_o |=> !load_we_o)
    else $error("refused word was loaded");
  a_inbound_answer: assert property (in_valid_i && !in_ready_o && !in_refused_o |=> in_ready_o != in_refused_o)
    else $error("inbound word not answered once");
  a_no_load_unasked: assert property (load_we_o |-> $past(in_ready_o))
    else $error("load without a taken word");
  a_load_after_take: assert property (in_ready_o |=> load_we_o && load_data_o == $past(in_data_i))
    else $error("taken word not loaded");
  a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus request not acknowledged once");
  a_lane_order: assert property (out_valid_o |-> out_o.lane == exp_lane)
    else $error("outbound lane out of order");
  a_out_holds: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_o))
    else $error("outbound word changed before taken");
  a_word_follows: assert property (out_valid_o && out_ready_i && !out_o.last |=> ##[0:4] out_valid_o)
    else $error("frame stream stalled");
  a_stop_after_last: assert property (out_valid_o && out_ready_i && out_o.last |=> !out_valid_o [*8])
    else $error("data presented after last frame");
endmodule : fbcc_top_checker

bind fbcc_top fbcc_top_checker fbcc_top_checker_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .in_valid_i,
  .in_data_i, .in_ready_o, .in_refused_o, .load_we_o, .load_data_o, .out_o, .out_valid_o, .out_ready_i);

//--- test/tb_top.sv
// Self-checking testbench for the fast block channel controller.
`timescale 1ns/100ps
module tb_top import fbcc_pkg::*; ;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, in_valid_i, in_ready_o, in_refused_o;
  logic        load_we_o, out_valid_o, out_ready_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i, in_chan_i, exp_ch;
  logic [31:0] dat_i, dat_o, q;
  logic [15:0] in_data_i, load_data_o, samp_data_i;
  logic [12:0] load_addr_o, samp_addr_o;
  fbcc_word_s  out_o;
  int          n_mismatch, n_compared, n_words, base_k, last_k;

  fbcc_top #(.NUM_CH(4), .LOAD_AW(13)) fbcc_top_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .in_valid_i, .in_chan_i, .in_data_i, .in_ready_o, .in_refused_o, .load_we_o,
    .load_addr_o, .load_data_o, .samp_addr_o, .samp_data_i, .out_o, .out_valid_o, .out_ready_i);
  fbcc_host_model fbcc_host_model_inst (.clk_i, .rst_i, .samp_addr_i(samp_addr_o), .samp_data_o(samp_data_i),
    .out_ready_o(out_ready_i));

  // ------------------------------------------------------------------
  // Checking and closing tasks
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------------
  // Bus and inbound access tasks
  // ------------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) begin n_mismatch++; tally_and_finish; end
    r = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic cmd(input logic [1:0] op, input logic [1:0] mode, input logic [3:0] ch, input logic has,
                     input logic [10:0] len, input logic [3:0] exp);
    fbcc_cmd_s c;
    logic [31:0] r;
    c = '0; c.op = op; c.mode = mode; c.chan = ch; c.has_chan = has; c.len = len;
    wb(1'b1, ADDR_CMD, c, r);
    wb(1'b0, ADDR_CMD, 32'h0, r);
    check("command result", r, {28'h0, exp});
  endtask : cmd

  task automatic conf(input logic [3:0] ch, input logic [2:0] code);
    logic [31:0] r;
    wb(1'b1, ADDR_CONF, {28'h0, ch}, r);
    wb(1'b0, ADDR_CONF, 32'h0, r);
    check("channel state", {21'h0, r[10:8], 4'h0, r[3:0]}, {21'h0, code, 4'h0, ch});
  endtask : conf

  task automatic in_word(input logic [3:0] ch, input logic [15:0] d, input logic ok);
    int n;
    in_valid_i <= 1'b1; in_chan_i <= ch; in_data_i <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (in_ready_o !== 1'b1 && in_refused_o !== 1'b1 && n < 50);
    if (in_ready_o !== 1'b1 && in_refused_o !== 1'b1) begin n_mismatch++; tally_and_finish; end
    in_valid_i <= 1'b0;
    check("inbound taken", {30'h0, in_ready_o, in_refused_o}, {30'h0, ok, !ok});
    @(posedge clk_i);
    if (ok) check("loaded word", {2'h0, load_addr_o, load_we_o, load_data_o}, {2'h0, 13'h0001, 1'b1, d});
  endtask : in_word

  task automatic wait_words(input int target);
    int n;
    n = 0;
    while (n_words < target && n < 70000) begin @(posedge clk_i); n++; end
    if (n >= 70000) begin n_mismatch++; tally_and_finish; end
  endtask : wait_words

  // Outbound monitor: every frame is eight lanes of memory words on one channel.
  always @(posedge clk_i) begin
    if (!rst_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      check("outbound word", {8'h0, out_o}, {8'h0, exp_ch, 3'(n_words - base_k), (n_words - base_k) == last_k,
            3'h5, 13'(n_words - base_k)});
      n_words++;
    end
  end

  // Clock at 200 MHz.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Main sequence of tests.
  initial begin
    {rst_i, cyc_i, stb_i, we_i, in_valid_i} = 5'h10;
    adr_i = 8'h00; sel_i = 4'h0; dat_i = 32'h0; in_chan_i = 4'h0; in_data_i = 16'h0;
    n_mismatch = 0; n_compared = 0; n_words = 0; base_k = 0; last_k = 15; exp_ch = 4'h1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, ADDR_SEL, 32'h0, q);
    check("selected channel", q, 32'h1);
    wb(1'b0, ADDR_BUF, 32'h0, q);
    check("buffer length", q, 32'h0);
    conf(4'h1, CONF_CLOSED);
    in_word(4'h1, 16'h0A0A, 1'b0);
    $display("test reset values done");
    cmd(OP_OPEN, MODE_OUT, 4'h0, 1'b0, 11'h0, 4'h0);
    conf(4'h1, CONF_OUT);
    in_word(4'h1, 16'h0B0B, 1'b0);
    cmd(OP_BUFFER, 2'h0, 4'h0, 1'b0, 11'h0, 4'h4);
    cmd(OP_BUFFER, 2'h0, 4'h0, 1'b0, 11'h401, 4'h4);
    cmd(OP_OPEN, 2'h3, 4'h2, 1'b1, 11'h0, 4'h2);
    cmd(OP_BUFFER, 2'h0, 4'h2, 1'b1, 11'h1, 4'h8);
    cmd(OP_OPEN, MODE_IN, 4'h5, 1'b1, 11'h0, 4'h1);
    $display("test command refusals done");
    cmd(OP_SELECT, 2'h0, 4'h2, 1'b0, 11'h0, 4'h0);
    wb(1'b0, ADDR_SEL, 32'h0, q);
    check("selected channel", q, 32'h2);
    cmd(OP_OPEN, MODE_BI, 4'h0, 1'b0, 11'h0, 4'h0);
    conf(4'h2, CONF_BIDIR);
    in_word(4'h2, 16'hBEEF, 1'b1);
    cmd(OP_OPEN, MODE_IN, 4'h3, 1'b1, 11'h0, 4'h0);
    conf(4'h3, CONF_IN);
    cmd(OP_BUFFER, 2'h0, 4'h3, 1'b1, 11'h1, 4'h8);
    in_word(4'h3, 16'h1234, 1'b1);
    $display("test directions done");
    cmd(OP_BUFFER, 2'h0, 4'h1, 1'b1, 11'h2, 4'h0);
    wait_words(16);
    repeat (40) @(posedge clk_i);
    check("frames sent", n_words, 16);
    wb(1'b0, ADDR_BUF, 32'h0, q);
    check("buffer bytes", {6'h0, q[25:0]}, {6'h0, 15'h0020, 11'h002});
    base_k = 16; last_k = 32'h1FFF; exp_ch = 4'h2;
    cmd(OP_BUFFER, 2'h0, 4'h0, 1'b0, LEN_MAX, 4'h0);
    wb(1'b0, ADDR_STAT, 32'h0, q);
    check("stream status", q, {16'h0, LEN_MAX, 4'h0, 1'b1});
    wait_words(32'h2010);
    repeat (40) @(posedge clk_i);
    check("frames sent", n_words, 32'h2010);
    wb(1'b0, ADDR_BUF, 32'h0, q);
    check("buffer bytes", {6'h0, q[25:0]}, {6'h0, 15'h4000, LEN_MAX});
    $display("test outbound frames done");
    cmd(OP_CLOSE, 2'h0, 4'h0, 1'b0, 11'h0, 4'h0);
    conf(4'h2, CONF_CLOSED);
    in_word(4'h2, 16'h5A5A, 1'b0);
    $display("test close done");
    tally_and_finish;
  end
endmodule : tb_top
